//--- rtl/gpcm_regs.vh
// register map, field positions and reset values of the pin configuration block
`ifndef GPCM_REGS_VH
`define GPCM_REGS_VH

// register indices; byte address is four times the index
`define GPCM_IDX_PIN_3_7 8'h3A
`define GPCM_IDX_PIN_4_0 8'h3B
`define GPCM_IDX_PIN_4_1 8'h3C
`define GPCM_IDX_PIN_4_2 8'h3D
`define GPCM_IDX_PIN_4_3 8'h3E
`define GPCM_IDX_INT_STATUS 8'h40
`define GPCM_IDX_INT_MASK 8'h41

// configuration fields
`define GPCM_BIT_DIR 0
`define GPCM_BIT_POL 1
`define GPCM_BIT_ALT 2
`define GPCM_BIT_FN_LO 2
`define GPCM_BIT_FN_HI 3
`define GPCM_BIT_ODRAIN 7
`define GPCM_CFG_RESET 8'h01

// function codes of the two-bit fields
`define GPCM_FN_GPIO 2'h0
`define GPCM_FN41_DENSITY1 2'h1
`define GPCM_FN41_EDGE_IRQ 2'h2
`define GPCM_FN43_DEV_DISABLE 2'h1
`define GPCM_FN43_EDGE_IRQ 2'h3

// interrupt status bits
`define GPCM_INT_EDGE_4_1 0
`define GPCM_INT_EDGE_4_3 1
`define GPCM_INT_WIDTH 2

// bus answers
`define GPCM_RESP_OKAY 2'h0
`define GPCM_RESP_SLVERR 2'h2

`endif

//--- rtl/gpcm_pin.v
// one pad: direction, polarity, driver type and alternate-function steering
`timescale 1ns/1ps
module gpcm_pin (
  input wire clock,
  input wire rstn,
  input wire [7:0] cfg,
  input wire alt_sel,
  input wire gpio_out,
  input wire alt_out,
  input wire pad_in,
  output wire value_in,
  output reg pad_out,
  output reg pad_oe
);
  `include "gpcm_regs.vh"

  wire is_input;
  wire invert;
  wire open_drain;
  wire drive_value;

  assign is_input = cfg[`GPCM_BIT_DIR]; // RULE1
  assign invert = cfg[`GPCM_BIT_POL]; // RULE2
  assign open_drain = cfg[`GPCM_BIT_ODRAIN];
  // alternate source replaces the gpio data path, direction and polarity still apply
  assign drive_value = (alt_sel ? alt_out : gpio_out) ^ invert; // RULE14
  assign value_in = pad_in ^ invert; // RULE2

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end else if (is_input) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end else if (open_drain) begin
      // open drain only ever pulls low; a high level comes from the pull-up
      pad_out <= 1'b0; // RULE3
      pad_oe <= ~drive_value; // RULE3
    end else begin
      pad_out <= drive_value; // RULE3
      pad_oe <= 1'b1;
    end
  end
endmodule // gpcm_pin

//--- rtl/gpcm_top.v
// configuration registers and pad steering for five general-purpose pins
//
// Summary of operation
// [RULE1] bit 0 of each pin register selects input when 1 and output when 0.
// [RULE2] bit 1 of each pin register inverts the pin's logical value when 1.
// [RULE3] bit 7 of each pin register selects open drain when 1 and push-pull when 0.
// [RULE4] every pin register loads 0x01 on standby power-on reset.
// [RULE5] register 3A bit 2 routes the gate-A20 mask to pin 3.7; bits 6 to 3 read zero.
// [RULE6] register 3B bit 2 routes drive density select 0 to pin 4.0.
// [RULE7] register 3C bits 3:2 pick gpio, density select 1, edge interrupt 2 or reserved.
// [RULE8] register 3D bit 2 routes the power-management event to pin 4.2.
// [RULE9] the power-management event drives active low when output and not inverted.
// [RULE10] register 3E bits 3:2 pick gpio, device-disable control, reserved or edge irq 3.
// [RULE11] the pin 4.3 function field clears on main-power and standby power-on reset.
// [RULE12] hard reset clears it too, and once device-disable control is chosen writes keep it.
// [RULE13] under device-disable control a high pin makes the disable register read-only.
// [RULE14] an alternate function replaces the gpio data path at the pad.
`timescale 1ns/1ps
module gpcm_top #(
  parameter ADDR_WIDTH = 12
) (
  input wire clock,
  input wire rstn,
  input wire main_power_reset,
  input wire hard_reset,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [4:0] gpio_out,
  output reg [4:0] gpio_in,
  input wire gate_a20_mask,
  input wire drive_density_sel_0,
  input wire drive_density_sel_1,
  input wire power_mgmt_event,
  input wire [4:0] pad_in,
  output wire [4:0] pad_out,
  output wire [4:0] pad_oe,
  output reg dev_disable_read_only,
  output wire irq
);
  `include "gpcm_regs.vh"

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // keeps only implemented bits; reserved bits always read zero
  function [7:0] cfg_keep;
    input [7:0] d;
    input wide_field;
    begin
      cfg_keep = {d[7], 3'h0, (wide_field ? d[3] : 1'b0), d[2:0]};
    end
  endfunction

  function [7:0] addr_index;
    input [ADDR_WIDTH-1:0] a;
    begin
      addr_index = a[9:2];
    end
  endfunction

  // ----------------------------------------------------------------
  // bus write path
  // ----------------------------------------------------------------
  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] aw_index_reg;
  reg [7:0] wdata_reg;
  reg wstrb_reg;
  wire wr_fire;
  wire lane0;
  reg wr_hit;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign lane0 = wstrb_reg;

  always @* begin
    case (aw_index_reg)
      `GPCM_IDX_PIN_3_7, `GPCM_IDX_PIN_4_0, `GPCM_IDX_PIN_4_1, `GPCM_IDX_PIN_4_2,
      `GPCM_IDX_PIN_4_3, `GPCM_IDX_INT_STATUS, `GPCM_IDX_INT_MASK: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_index_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPCM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_index_reg <= addr_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0]; // only byte lane 0 holds register bits
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `GPCM_RESP_OKAY : `GPCM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [7:0] cfg_reg [0:4];
  wire [7:0] wr_byte;
  wire fn43_locked;
  integer i;

  assign wr_byte = wdata_reg;
  assign fn43_locked = cfg_reg[4][3:2] == `GPCM_FN43_DEV_DISABLE;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 5; i = i + 1) begin
        cfg_reg[i] <= `GPCM_CFG_RESET; // RULE4
      end
    end else begin
      if (wr_fire && lane0) begin
        case (aw_index_reg)
          `GPCM_IDX_PIN_3_7: begin
            cfg_reg[0] <= cfg_keep(wr_byte, 1'b0); // RULE5
          end
          `GPCM_IDX_PIN_4_0: begin
            cfg_reg[1] <= cfg_keep(wr_byte, 1'b0); // RULE6
          end
          `GPCM_IDX_PIN_4_1: begin
            cfg_reg[2] <= cfg_keep(wr_byte, 1'b1); // RULE7
          end
          `GPCM_IDX_PIN_4_2: begin
            cfg_reg[3] <= cfg_keep(wr_byte, 1'b0); // RULE8
          end
          `GPCM_IDX_PIN_4_3: begin
            cfg_reg[4][7] <= wr_byte[7];
            cfg_reg[4][1:0] <= wr_byte[1:0];
            // the field is sticky once device-disable control is chosen
            if (!fn43_locked) begin
              cfg_reg[4][3:2] <= wr_byte[3:2]; // RULE12 RULE10
            end
          end
          default: begin
          end
        endcase
      end
      // later assignment wins over a simultaneous write
      if (main_power_reset || hard_reset) begin
        cfg_reg[4][3:2] <= `GPCM_FN_GPIO; // RULE11 RULE12
      end
    end
  end

  // ----------------------------------------------------------------
  // function decode and pads
  // ----------------------------------------------------------------
  wire [1:0] fn41;
  wire [1:0] fn43;
  wire [4:0] alt_sel;
  wire [4:0] alt_out;
  wire [4:0] value_in;

  assign fn41 = cfg_reg[2][3:2];
  assign fn43 = cfg_reg[4][3:2];
  assign alt_sel[0] = cfg_reg[0][`GPCM_BIT_ALT]; // RULE5
  assign alt_sel[1] = cfg_reg[1][`GPCM_BIT_ALT]; // RULE6
  // reserved codes fall back to plain gpio
  assign alt_sel[2] = fn41 == `GPCM_FN41_DENSITY1; // RULE7
  assign alt_sel[3] = cfg_reg[3][`GPCM_BIT_ALT]; // RULE8
  assign alt_sel[4] = 1'b0; // both 4.3 functions are inputs only
  assign alt_out[0] = gate_a20_mask;
  assign alt_out[1] = drive_density_sel_0;
  assign alt_out[2] = drive_density_sel_1;
  // event is active high inside; non-inverted polarity gives a low pad
  assign alt_out[3] = ~power_mgmt_event; // RULE9
  assign alt_out[4] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : pin
      gpcm_pin u_pin (
        .clock(clock),
        .rstn(rstn),
        .cfg(cfg_reg[g]),
        .alt_sel(alt_sel[g]),
        .gpio_out(gpio_out[g]),
        .alt_out(alt_out[g]),
        .pad_in(pad_in[g]),
        .value_in(value_in[g]),
        .pad_out(pad_out[g]),
        .pad_oe(pad_oe[g])
      );
    end
  endgenerate

  reg [4:0] value_prev_reg;
  wire edge41;
  wire edge43;

  assign edge41 = (fn41 == `GPCM_FN41_EDGE_IRQ) && (value_in[2] != value_prev_reg[2]); // RULE7
  assign edge43 = (fn43 == `GPCM_FN43_EDGE_IRQ) && (value_in[4] != value_prev_reg[4]); // RULE10

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      value_prev_reg <= 5'h00;
      gpio_in <= 5'h00;
      dev_disable_read_only <= 1'b0;
    end else begin
      value_prev_reg <= value_in;
      gpio_in <= value_in;
      // raw pin level, not the polarity-adjusted value
      dev_disable_read_only <= (fn43 == `GPCM_FN43_DEV_DISABLE) && pad_in[4]; // RULE13
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  reg [`GPCM_INT_WIDTH-1:0] int_status_reg;
  reg [`GPCM_INT_WIDTH-1:0] int_mask_reg;
  wire [`GPCM_INT_WIDTH-1:0] int_set;
  wire [`GPCM_INT_WIDTH-1:0] int_clr;
  wire status_wr;

  assign int_set = {edge43, edge41};
  assign status_wr = wr_fire && lane0 && (aw_index_reg == `GPCM_IDX_INT_STATUS);
  assign int_clr = status_wr ? wr_byte[`GPCM_INT_WIDTH-1:0] : {`GPCM_INT_WIDTH{1'b0}};
  assign irq = |(int_status_reg & int_mask_reg);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_status_reg <= {`GPCM_INT_WIDTH{1'b0}};
      int_mask_reg <= {`GPCM_INT_WIDTH{1'b0}};
    end else begin
      // a new event in the clearing cycle survives
      int_status_reg <= (int_status_reg & ~int_clr) | int_set;
      if (wr_fire && lane0 && (aw_index_reg == `GPCM_IDX_INT_MASK)) begin
        int_mask_reg <= wr_byte[`GPCM_INT_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus read path
  // ----------------------------------------------------------------
  reg [31:0] rd_data;
  reg rd_hit;
  wire [7:0] ar_index;

  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_index = addr_index(s_axi_araddr);

  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (ar_index)
      `GPCM_IDX_PIN_3_7: begin
        rd_data[7:0] = cfg_reg[0];
      end
      `GPCM_IDX_PIN_4_0: begin
        rd_data[7:0] = cfg_reg[1];
      end
      `GPCM_IDX_PIN_4_1: begin
        rd_data[7:0] = cfg_reg[2];
      end
      `GPCM_IDX_PIN_4_2: begin
        rd_data[7:0] = cfg_reg[3];
      end
      `GPCM_IDX_PIN_4_3: begin
        rd_data[7:0] = cfg_reg[4];
      end
      `GPCM_IDX_INT_STATUS: begin
        rd_data[`GPCM_INT_WIDTH-1:0] = int_status_reg;
      end
      `GPCM_IDX_INT_MASK: begin
        rd_data[`GPCM_INT_WIDTH-1:0] = int_mask_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GPCM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `GPCM_RESP_OKAY : `GPCM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // gpcm_top

//--- testbench/gpcm_checker.sv
// checker: port-level properties of the pin configuration block
`timescale 1ns/1ps
`include "gpcm_regs.vh"
module gpcm_checker #(
  parameter ADDR_WIDTH = 12
) (
  input wire clock,
  input wire rstn,
  input wire main_power_reset,
  input wire hard_reset,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire [4:0] gpio_out,
  input wire gate_a20_mask,
  input wire drive_density_sel_0,
  input wire drive_density_sel_1,
  input wire power_mgmt_event,
  input wire [4:0] pad_in,
  input wire [4:0] pad_out,
  input wire [4:0] pad_oe,
  input wire [4:0] gpio_in,
  input wire dev_disable_read_only
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire [8:0] src = {gpio_out, gate_a20_mask, drive_density_sel_0, drive_density_sel_1,
    power_mgmt_event};
  reg wrote_reg;
  reg [7:0] rd_idx_reg;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // any write response counts: cheaper than decoding, only loosens the idle check
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrote_reg <= 1'b0;
      rd_idx_reg <= 8'h00;
    end else begin
      wrote_reg <= wrote_reg | s_axi_bvalid;
      if (s_axi_arvalid && s_axi_arready)
        rd_idx_reg <= s_axi_araddr[9:2];
    end
  end
  sequence s_cleared;
    ##2 !dev_disable_read_only;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_idle; !wrote_reg |-> pad_oe == 5'h00; endproperty
  a_idle: assert property (p_idle)
    else $error("pad driven before any write");
  property p_in_cause; $changed(gpio_in) && $past(rstn, 2) |->
    $past(s_axi_bvalid) || $past(pad_in) != $past(pad_in, 2); endproperty
  a_in_cause: assert property (p_in_cause)
    else $error("gpio_in moved without cause");
  // pads are registered: a change needs a config update or a source change one edge earlier
  property p_pad_cause; $changed({pad_out, pad_oe}) && $past(rstn, 2) |->
    $past(s_axi_bvalid) || $past(src) != $past(src, 2); endproperty
  a_pad_cause: assert property (p_pad_cause)
    else $error("pad moved without cause");
  property p_ro_src; dev_disable_read_only |-> $past(pad_in[4]); endproperty
  a_ro_src: assert property (p_ro_src)
    else $error("read-only without high pin");
  property p_ro_low; !pad_in[4] |=> !dev_disable_read_only; endproperty
  a_ro_low: assert property (p_ro_low)
    else $error("read-only kept with low pin");
  property p_main_clr; main_power_reset |-> s_cleared; endproperty
  a_main_clr: assert property (p_main_clr)
    else $error("field kept after main reset");
  property p_hard_clr; hard_reset |-> s_cleared; endproperty
  a_hard_clr: assert property (p_hard_clr)
    else $error("field kept after hard reset");
  property p_rsv; s_axi_rvalid && rd_idx_reg == `GPCM_IDX_PIN_3_7 |->
    s_axi_rdata[6:3] == 4'h0; endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits read nonzero");
endmodule // gpcm_checker

bind gpcm_top gpcm_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.clock(clock), .rstn(rstn),
  .main_power_reset(main_power_reset), .hard_reset(hard_reset),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .gpio_out(gpio_out), .gate_a20_mask(gate_a20_mask),
  .drive_density_sel_0(drive_density_sel_0), .drive_density_sel_1(drive_density_sel_1),
  .power_mgmt_event(power_mgmt_event), .pad_in(pad_in), .pad_out(pad_out),
  .pad_oe(pad_oe), .gpio_in(gpio_in), .dev_disable_read_only(dev_disable_read_only));

//--- testbench/tb.sv
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
`include "gpcm_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb;
  logic clock = 1'b0;
  logic rstn = 1'b0, mpr = 1'b0, hrd = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [4:0] go = 5'h00, pin = 5'h01;
  logic [3:0] alt = 4'h0;
  logic [3:0] ws = 4'hF;
  wire awr, wrd, bv, arr, rv, irq, ro;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] gin, pout, poe;
  int errors = 0, n_checks = 0;
  gpcm_top uut (.clock(clock), .rstn(rstn), .main_power_reset(mpr), .hard_reset(hrd),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .gpio_out(go), .gpio_in(gin), .gate_a20_mask(alt[3]),
    .drive_density_sel_0(alt[2]), .drive_density_sel_1(alt[1]),
    .power_mgmt_event(alt[0]), .pad_in(pin), .pad_out(pout), .pad_oe(poe),
    .dev_disable_read_only(ro), .irq(irq));
  initial forever #2 clock = ~clock;
  // ----------------------------------------
  // bus and utility tasks
  // ----------------------------------------
  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic st;
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic tmo(input logic d);
    if (d !== 1'b1) begin
      errors++;
      conclude;
    end
  endtask
  // readies sampled at the falling edge: nothing moves before the next rising edge
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] e);
    logic a, w, done;
    logic [1:0] r;
    done = 1'b0;
    @(posedge clock);
    awa <= {2'h0, i, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clock);
      a = awr;
      w = wrd;
      done = bv;
      r = bresp;
      @(posedge clock);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
      if (done) br <= 1'b0;
    end
    tmo(done);
    `CHK(r, e)
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    logic a, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    @(posedge clock);
    ara <= {2'h0, i, 2'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clock);
      a = arr;
      done = rv;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (a) arv <= 1'b0;
      if (done) rr <= 1'b0;
    end
    tmo(done);
    `CHK(d, e)
    `CHK(r, er)
  endtask
  task automatic pp(input logic [7:0] c, input logic g, input logic [1:0] e);
    wr(8'h3A, {24'h0, c}, 2'h0);
    go[0] <= g;
    st;
    `CHK({pout[0], poe[0]}, e)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rd(8'h3A + i[7:0], 32'h01, 2'h0);
    rd(8'h3F, 32'h0, 2'h2);
    wr(8'h3F, 32'hFF, 2'h2);
    st;
    `CHK(poe, 5'h00)
    `CHK(gin[0], 1'b1)
  endtask
  task automatic t_pads;
    // byte lane 0 off: the write is answered but must change nothing
    @(posedge clock);
    ws <= 4'hE;
    wr(8'h3A, 32'h00, 2'h0);
    ws <= 4'hF;
    rd(8'h3A, 32'h01, 2'h0);
    pp(8'h00, 1'b1, 2'h3);
    pp(8'h02, 1'b1, 2'h1);
    pp(8'h80, 1'b1, 2'h0);
    pp(8'h80, 1'b0, 2'h1);
    wr(8'h3A, 32'h03, 2'h0);
    st;
    `CHK(gin[0], 1'b0)
  endtask
  task automatic t_alt;
    for (int i = 0; i < 4; i++) wr(8'h3A + i[7:0], 32'h04, 2'h0);
    alt <= 4'hF;
    go <= 5'h00;
    st;
    `CHK(pout[3:0], 4'h7)
    `CHK(poe[3:0], 4'hF)
    @(posedge clock);
    alt <= 4'hE;
    st;
    `CHK(pout[3], 1'b1)
    wr(8'h3A, 32'hFF, 2'h0);
    rd(8'h3A, 32'h87, 2'h0);
    wr(8'h3C, 32'hFF, 2'h0);
    rd(8'h3C, 32'h8F, 2'h0);
  endtask
  // status cleared after selection: the first sample may raise a stale event
  task automatic t_edge;
    wr(8'h3C, 32'h09, 2'h0);
    wr(8'h3E, 32'h0D, 2'h0);
    wr(8'h41, 32'h03, 2'h0);
    wr(8'h40, 32'h03, 2'h0);
    st;
    `CHK(irq, 1'b0)
    @(posedge clock);
    pin[2] <= ~pin[2];
    st;
    `CHK(irq, 1'b1)
    rd(8'h40, 32'h01, 2'h0);
    wr(8'h40, 32'h01, 2'h0);
    pin[4] <= ~pin[4];
    st;
    rd(8'h40, 32'h02, 2'h0);
    wr(8'h41, 32'h00, 2'h0);
    st;
    `CHK(irq, 1'b0)
    wr(8'h40, 32'h03, 2'h0);
    wr(8'h3E, 32'h01, 2'h0);
  endtask
  task automatic t_lock;
    wr(8'h3E, 32'h05, 2'h0);
    pin[4] <= 1'b0;
    st;
    `CHK(ro, 1'b0)
    @(posedge clock);
    pin[4] <= 1'b1;
    st;
    `CHK(ro, 1'b1)
    wr(8'h3E, 32'h0F, 2'h0);
    rd(8'h3E, 32'h07, 2'h0);
    @(posedge clock);
    mpr <= 1'b1;
    @(posedge clock);
    mpr <= 1'b0;
    rd(8'h3E, 32'h03, 2'h0);
    st;
    `CHK(ro, 1'b0)
    wr(8'h3E, 32'h05, 2'h0);
    @(posedge clock);
    hrd <= 1'b1;
    @(posedge clock);
    hrd <= 1'b0;
    rd(8'h3E, 32'h01, 2'h0);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_pads;
    t_alt;
    t_edge;
    t_lock;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    conclude;
  end
endmodule // tb
